// File: icmdc_pkg.sv
// Constants, codes and types for the channel mode and diagnosis configuration block
package icmdc_pkg;

	// ********************************************************************
	// Sizes
	// ********************************************************************
	localparam int NUM_PORTS = 8;
	localparam int NUM_CH = 16;
	localparam int PORT_DIAG_PORTS = 2;
	// Index of the first port that owns a per-port diagnosis enable (port 7)
	localparam int PORT_DIAG_FIRST = 6;

	// ********************************************************************
	// Configuration assembly byte offsets
	// ********************************************************************
	localparam logic [7:0] OFS_MODE_A_LO = 8'h00;
	localparam logic [7:0] OFS_MODE_A_HI = 8'h01;
	localparam logic [7:0] OFS_MODE_B_LO = 8'h02;
	localparam logic [7:0] OFS_MODE_B_HI = 8'h03;
	localparam logic [7:0] OFS_MST_DIAG = 8'hd0;
	localparam logic [7:0] OFS_DEV_ERR = 8'hd1;
	localparam logic [7:0] OFS_DEV_WARN = 8'hd2;
	localparam logic [7:0] OFS_DEV_NOTE = 8'hd3;
	localparam logic [7:0] OFS_PORT_DIAG_LO = 8'hda;
	localparam logic [7:0] OFS_PORT_DIAG_HI = 8'hdb;
	localparam logic [7:0] OFS_STATUS = 8'hf0;

	// ********************************************************************
	// Field codes and reset values
	// ********************************************************************
	localparam logic [1:0] CODE_A_IOL = 2'h0;
	localparam logic [1:0] CODE_A_DOUT = 2'h1;
	localparam logic [1:0] CODE_A_DIN = 2'h2;
	localparam logic [1:0] CODE_A_OFF = 2'h3;
	localparam logic [1:0] CODE_B_DIN = 2'h0;
	localparam logic [1:0] CODE_B_DOUT = 2'h1;
	localparam logic [1:0] CODE_B_AUX = 2'h2;
	localparam logic [1:0] CODE_B_OFF = 2'h3;
	localparam logic [7:0] ENA_OFF = 8'h00;
	localparam logic [7:0] ENA_ON = 8'h01;
	localparam logic [15:0] MODE_WORD_RST = 16'hffff;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_REJECT_BIT = 1;

	// ********************************************************************
	// Hardware capability of the variant
	// ********************************************************************
	localparam logic [NUM_PORTS-1:0] IOL_CAP_A = 8'hc0;
	localparam logic [NUM_PORTS-1:0] CLASS_B_PORTS = 8'h00;
	localparam logic [NUM_PORTS-1:0] B_DI_CAP = 8'hff;

	typedef enum logic [2:0] {
		CM_INACTIVE,
		CM_DOUT,
		CM_DIN,
		CM_IOL,
		CM_AUX
	} icmdc_mode_e;

endpackage

// File: icmdc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module icmdc_sync #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// File: icmdc_top.sv
// Channel mode decode and diagnosis gating for an eight-port I/O module
`timescale 1ns/10ps

// What this block does
// - A port whose first channel is inactive has its second channel forced inactive too.
// - A digital output channel drives from the output control word or the link output byte.
// - A digital input channel shows its pin state in the input pin state word.
// - A channel in IO-Link mode requests link start-up with an attached device.
// - IO-Link is allowed only where hardware supports it, never on a second channel.
// - The first-channel mode word packs two bits per port, port 1 lowest.
// - First-channel codes mean IO-Link, digital output, digital input, inactive.
// - The second-channel mode word packs two bits per port, port 1 lowest.
// - Second-channel codes mean digital input, digital output, auxiliary power, inactive.
// - Master diagnoses are reported only while the master diagnosis enable is set.
// - Device errors are reported only while the device error enable is set.
// - Device warnings are reported only while the device warning enable is set.
// - Device notifications are reported only while the notification enable is set.
// - Ports 7 and 8 each have an enable that gates all their diagnoses.
// - Enabled diagnoses add detail to extended status and events when those are configured.
// - Channel 2p-1 is port p first channel and channel 2p is port p second channel.
module icmdc_top
	import icmdc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration assembly write and read
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wr_addr,
	input wire logic [7:0] cfg_wr_data,
	input wire logic cfg_commit,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_rd_addr,
	output logic [7:0] cfg_rd_data,
	output logic cfg_accepted,
	output logic cfg_rejected,
	// General settings
	input wire logic do_src_iol,
	input wire logic ext_status_cfg,
	input wire logic event_cfg,
	// Cyclic output data
	input wire logic [15:0] do_ctrl_word,
	input wire logic [63:0] iol_out_byte0,
	// Physical channel pins
	input wire logic [15:0] di_pins,
	output logic [15:0] do_drive,
	// Cyclic input data
	output logic [15:0] di_state_word,
	// Decoded channel modes
	output logic [47:0] chan_mode,
	output logic [7:0] iol_start,
	output logic [7:0] aux_power_en,
	// Raw diagnosis events per port
	input wire logic [7:0] mst_diag_evt,
	input wire logic [7:0] dev_err_evt,
	input wire logic [7:0] dev_warn_evt,
	input wire logic [7:0] dev_note_evt,
	// Gated diagnosis per port
	output logic [7:0] mst_diag_rep,
	output logic [7:0] dev_err_rep,
	output logic [7:0] dev_warn_rep,
	output logic [7:0] dev_note_rep,
	output logic [7:0] ext_status_detail,
	output logic [7:0] event_detail
);

	// ********************************************************************
	// Decode helpers
	// ********************************************************************
	function automatic icmdc_mode_e decode_a(input logic [1:0] code, input logic iol_cap);
		icmdc_mode_e m;
		m = CM_INACTIVE;
		unique case (code)
			CODE_A_IOL: m = iol_cap ? CM_IOL : CM_DIN;
			CODE_A_DOUT: m = CM_DOUT;
			CODE_A_DIN: m = CM_DIN;
			CODE_A_OFF: m = CM_INACTIVE;
		endcase
		return m;
	endfunction

	function automatic icmdc_mode_e decode_b(input logic [1:0] code, input logic class_b,
			input logic di_cap);
		icmdc_mode_e m;
		m = CM_INACTIVE;
		unique case (code)
			CODE_B_DIN: m = (class_b && !di_cap) ? CM_AUX : CM_DIN;
			CODE_B_DOUT: m = CM_DOUT;
			CODE_B_AUX: m = CM_AUX;
			CODE_B_OFF: m = CM_INACTIVE;
		endcase
		return m;
	endfunction

	function automatic logic enable_ok(input logic [7:0] v);
		return (v == ENA_OFF) || (v == ENA_ON);
	endfunction

	// ********************************************************************
	// Staged configuration bytes
	// ********************************************************************
	logic [15:0] mode_a_stage_reg;
	logic [15:0] mode_b_stage_reg;
	logic [7:0] mst_diag_stage_reg;
	logic [7:0] dev_err_stage_reg;
	logic [7:0] dev_warn_stage_reg;
	logic [7:0] dev_note_stage_reg;
	logic [7:0] port_diag_stage_reg [PORT_DIAG_PORTS];

	always_ff @(posedge clk) begin
		if (reset) begin
			mode_a_stage_reg <= MODE_WORD_RST;
			mode_b_stage_reg <= MODE_WORD_RST;
			mst_diag_stage_reg <= BYTE_RST;
			dev_err_stage_reg <= BYTE_RST;
			dev_warn_stage_reg <= BYTE_RST;
			dev_note_stage_reg <= BYTE_RST;
			port_diag_stage_reg[0] <= BYTE_RST;
			port_diag_stage_reg[1] <= BYTE_RST;
		end else if (cfg_wr) begin
			unique case (cfg_wr_addr)
				OFS_MODE_A_LO: mode_a_stage_reg[7:0] <= cfg_wr_data;
				OFS_MODE_A_HI: mode_a_stage_reg[15:8] <= cfg_wr_data;
				OFS_MODE_B_LO: mode_b_stage_reg[7:0] <= cfg_wr_data;
				OFS_MODE_B_HI: mode_b_stage_reg[15:8] <= cfg_wr_data;
				OFS_MST_DIAG: mst_diag_stage_reg <= cfg_wr_data;
				OFS_DEV_ERR: dev_err_stage_reg <= cfg_wr_data;
				OFS_DEV_WARN: dev_warn_stage_reg <= cfg_wr_data;
				OFS_DEV_NOTE: dev_note_stage_reg <= cfg_wr_data;
				OFS_PORT_DIAG_LO: port_diag_stage_reg[0] <= cfg_wr_data;
				OFS_PORT_DIAG_HI: port_diag_stage_reg[1] <= cfg_wr_data;
				default: ;
			endcase
		end
	end

	// ********************************************************************
	// Validation of the staged set
	// ********************************************************************
	logic [NUM_PORTS-1:0] port_code_ok;
	logic cfg_ok;

	// Auxiliary power on a second channel needs a class B port
	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_check
			assign port_code_ok[p] = (mode_b_stage_reg[2*p +: 2] != CODE_B_AUX) ||
				CLASS_B_PORTS[p];
		end
	endgenerate

	assign cfg_ok = (&port_code_ok) &&
		enable_ok(mst_diag_stage_reg) && enable_ok(dev_err_stage_reg) &&
		enable_ok(dev_warn_stage_reg) && enable_ok(dev_note_stage_reg) &&
		enable_ok(port_diag_stage_reg[0]) && enable_ok(port_diag_stage_reg[1]);

	// ********************************************************************
	// Active configuration, loaded only on an accepted commit
	// ********************************************************************
	logic [15:0] mode_a_act_reg;
	logic [15:0] mode_b_act_reg;
	logic mst_diag_en_reg;
	logic dev_err_en_reg;
	logic dev_warn_en_reg;
	logic dev_note_en_reg;
	logic [PORT_DIAG_PORTS-1:0] port_diag_en_reg;
	logic cfg_active_reg;
	logic cfg_reject_flag_reg;

	// A refused set leaves the running configuration untouched
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_a_act_reg <= MODE_WORD_RST;
			mode_b_act_reg <= MODE_WORD_RST;
			mst_diag_en_reg <= 1'b0;
			dev_err_en_reg <= 1'b0;
			dev_warn_en_reg <= 1'b0;
			dev_note_en_reg <= 1'b0;
			port_diag_en_reg <= '0;
		end else if (cfg_commit && cfg_ok) begin
			mode_a_act_reg <= mode_a_stage_reg;
			mode_b_act_reg <= mode_b_stage_reg;
			mst_diag_en_reg <= mst_diag_stage_reg[0];
			dev_err_en_reg <= dev_err_stage_reg[0];
			dev_warn_en_reg <= dev_warn_stage_reg[0];
			dev_note_en_reg <= dev_note_stage_reg[0];
			port_diag_en_reg <= {port_diag_stage_reg[1][0], port_diag_stage_reg[0][0]};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_active_reg <= 1'b0;
			cfg_reject_flag_reg <= 1'b0;
			cfg_accepted <= 1'b0;
			cfg_rejected <= 1'b0;
		end else begin
			cfg_accepted <= cfg_commit && cfg_ok;
			cfg_rejected <= cfg_commit && !cfg_ok;
			if (cfg_commit) begin
				cfg_active_reg <= cfg_active_reg || cfg_ok;
				cfg_reject_flag_reg <= !cfg_ok;
			end
		end
	end

	// ********************************************************************
	// Register read-back
	// ********************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_rd_data <= BYTE_RST;
		end else if (cfg_rd) begin
			unique case (cfg_rd_addr)
				OFS_MODE_A_LO: cfg_rd_data <= mode_a_stage_reg[7:0];
				OFS_MODE_A_HI: cfg_rd_data <= mode_a_stage_reg[15:8];
				OFS_MODE_B_LO: cfg_rd_data <= mode_b_stage_reg[7:0];
				OFS_MODE_B_HI: cfg_rd_data <= mode_b_stage_reg[15:8];
				OFS_MST_DIAG: cfg_rd_data <= mst_diag_stage_reg;
				OFS_DEV_ERR: cfg_rd_data <= dev_err_stage_reg;
				OFS_DEV_WARN: cfg_rd_data <= dev_warn_stage_reg;
				OFS_DEV_NOTE: cfg_rd_data <= dev_note_stage_reg;
				OFS_PORT_DIAG_LO: cfg_rd_data <= port_diag_stage_reg[0];
				OFS_PORT_DIAG_HI: cfg_rd_data <= port_diag_stage_reg[1];
				OFS_STATUS: begin
					cfg_rd_data <= BYTE_RST;
					cfg_rd_data[STAT_ACTIVE_BIT] <= cfg_active_reg;
					cfg_rd_data[STAT_REJECT_BIT] <= cfg_reject_flag_reg;
				end
				default: cfg_rd_data <= BYTE_RST;
			endcase
		end
	end

	// ********************************************************************
	// Channel mode decode
	// ********************************************************************
	icmdc_mode_e mode_a_dec [NUM_PORTS];
	icmdc_mode_e mode_b_dec [NUM_PORTS];
	logic [15:0] di_sync;
	logic [NUM_PORTS-1:0] port_diag_gate;

	icmdc_sync #(
		.WIDTH(NUM_CH)
	) u_di_sync (
		.clk(clk),
		.reset(reset),
		.async_in(di_pins),
		.sync_out(di_sync)
	);

	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			assign mode_a_dec[p] = decode_a(mode_a_act_reg[2*p +: 2], IOL_CAP_A[p]);
			// Second channel never decodes to IO-Link
			assign mode_b_dec[p] = (mode_a_dec[p] == CM_INACTIVE) ? CM_INACTIVE :
				decode_b(mode_b_act_reg[2*p +: 2], CLASS_B_PORTS[p], B_DI_CAP[p]);

			if (p >= PORT_DIAG_FIRST) begin : g_pd
				assign port_diag_gate[p] = port_diag_en_reg[p-PORT_DIAG_FIRST];
			end else begin : g_npd
				assign port_diag_gate[p] = 1'b1;
			end

			// Channel 2p is the first channel, 2p+1 the second
			always_ff @(posedge clk) begin
				if (reset) begin
					chan_mode[6*p +: 3] <= CM_INACTIVE;
					chan_mode[6*p+3 +: 3] <= CM_INACTIVE;
					iol_start[p] <= 1'b0;
					aux_power_en[p] <= 1'b0;
				end else begin
					chan_mode[6*p +: 3] <= mode_a_dec[p];
					chan_mode[6*p+3 +: 3] <= mode_b_dec[p];
					iol_start[p] <= mode_a_dec[p] == CM_IOL;
					aux_power_en[p] <= mode_b_dec[p] == CM_AUX;
				end
			end

			// Output source: control word bit or link byte bit 0 (A) / bit 1 (B)
			always_ff @(posedge clk) begin
				if (reset) begin
					do_drive[2*p] <= 1'b0;
					do_drive[2*p+1] <= 1'b0;
				end else begin
					do_drive[2*p] <= (mode_a_dec[p] == CM_DOUT) &&
						(do_src_iol ? iol_out_byte0[8*p] : do_ctrl_word[2*p]);
					do_drive[2*p+1] <= (mode_b_dec[p] == CM_DOUT) &&
						(do_src_iol ? iol_out_byte0[8*p+1] : do_ctrl_word[2*p+1]);
				end
			end

			// Channels not in input mode read as zero
			always_ff @(posedge clk) begin
				if (reset) begin
					di_state_word[2*p] <= 1'b0;
					di_state_word[2*p+1] <= 1'b0;
				end else begin
					di_state_word[2*p] <= (mode_a_dec[p] == CM_DIN) && di_sync[2*p];
					di_state_word[2*p+1] <= (mode_b_dec[p] == CM_DIN) &&
						di_sync[2*p+1];
				end
			end
		end
	endgenerate

	// ********************************************************************
	// Diagnosis gating
	// ********************************************************************
	logic [7:0] diag_port_ok;
	logic [7:0] mst_diag_next;
	logic [7:0] dev_err_next;
	logic [7:0] dev_warn_next;
	logic [7:0] dev_note_next;

	// Only ports running a link can carry link diagnoses
	assign diag_port_ok = iol_start & port_diag_gate;
	assign mst_diag_next = mst_diag_evt & diag_port_ok & {8{mst_diag_en_reg}};
	assign dev_err_next = dev_err_evt & diag_port_ok & {8{dev_err_en_reg}};
	assign dev_warn_next = dev_warn_evt & diag_port_ok & {8{dev_warn_en_reg}};
	assign dev_note_next = dev_note_evt & diag_port_ok & {8{dev_note_en_reg}};

	always_ff @(posedge clk) begin
		if (reset) begin
			mst_diag_rep <= '0;
			dev_err_rep <= '0;
			dev_warn_rep <= '0;
			dev_note_rep <= '0;
		end else begin
			mst_diag_rep <= mst_diag_next;
			dev_err_rep <= dev_err_next;
			dev_warn_rep <= dev_warn_next;
			dev_note_rep <= dev_note_next;
		end
	end

	// Detail appears only in sections the assembly actually carries
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_status_detail <= '0;
			event_detail <= '0;
		end else begin
			ext_status_detail <= (mst_diag_next | dev_err_next | dev_warn_next | dev_note_next) &
				{8{ext_status_cfg}};
			event_detail <= (mst_diag_next | dev_err_next | dev_warn_next | dev_note_next) &
				{8{event_cfg}};
		end
	end

endmodule

// File: icmdc_chk.sv
// Assertion checker for the channel mode and diagnosis block
`timescale 1ns/10ps
module icmdc_chk
	import icmdc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Stimulus
	input wire logic cfg_commit,
	input wire logic do_src_iol,
	input wire logic ext_status_cfg,
	input wire logic event_cfg,
	input wire logic [15:0] do_ctrl_word,
	input wire logic [63:0] iol_out_byte0,
	input wire logic [7:0] mst_diag_evt,
	input wire logic [7:0] dev_err_evt,
	input wire logic [7:0] dev_warn_evt,
	input wire logic [7:0] dev_note_evt,
	// Responses
	input wire logic cfg_accepted,
	input wire logic cfg_rejected,
	input wire logic [15:0] do_drive,
	input wire logic [15:0] di_state_word,
	input wire logic [47:0] chan_mode,
	input wire logic [7:0] iol_start,
	input wire logic [7:0] aux_power_en,
	input wire logic [7:0] mst_diag_rep,
	input wire logic [7:0] dev_err_rep,
	input wire logic [7:0] dev_warn_rep,
	input wire logic [7:0] dev_note_rep,
	input wire logic [7:0] ext_status_detail,
	input wire logic [7:0] event_detail
);
	logic [15:0] dout_m, din_m, src_bit;
	logic [7:0] any_rep;
	logic [31:0] evt_all, rep_all;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			dout_m[c] = chan_mode[3*c+:3] == CM_DOUT;
			din_m[c] = chan_mode[3*c+:3] == CM_DIN;
			src_bit[c] = do_src_iol ? iol_out_byte0[8*(c/2)+c%2] : do_ctrl_word[c];
		end
	end
	assign any_rep = mst_diag_rep | dev_err_rep | dev_warn_rep | dev_note_rep;
	assign evt_all = {mst_diag_evt, dev_err_evt, dev_warn_evt, dev_note_evt};
	assign rep_all = {mst_diag_rep, dev_err_rep, dev_warn_rep, dev_note_rep};

	// ********
	// Commit handshake
	// ********
	sequence s_commit;
		cfg_commit;
	endsequence
	sequence s_reply;
		cfg_accepted ^ cfg_rejected;
	endsequence

	chk_commit_reply: assert property (s_commit |=> s_reply)
		else $error("commit without single reply");
	chk_reply_cause: assert property ((cfg_accepted || cfg_rejected)
		|-> $past(cfg_commit))
		else $error("reply without commit");
	chk_mode_hold: assert property ($changed(chan_mode) |-> $past(cfg_accepted))
		else $error("modes moved without accepted commit");
	chk_dout_src: assert property (do_drive == (dout_m & $past(src_bit)))
		else $error("output drive wrong");
	chk_din_only: assert property ((di_state_word & ~din_m) == 16'h0000)
		else $error("input state on non-input channel");
	// Gate uses the link flag as it stood when the report was launched
	chk_diag_gate: assert property ((rep_all &
		~($past(evt_all) & {4{$past(iol_start)}})) == 32'h0)
		else $error("diagnosis without cause");
	chk_ext_detail: assert property (ext_status_detail ==
		(any_rep & {8{$past(ext_status_cfg)}})
		&& event_detail == (any_rep & {8{$past(event_cfg)}}))
		else $error("detail gating wrong");

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		chk_port_off: assert property (chan_mode[6*p+:3] == CM_INACTIVE
			|-> chan_mode[6*p+3+:3] == CM_INACTIVE)
			else $error("second channel live on dead port");
		chk_iol_place: assert property (chan_mode[6*p+3+:3] != CM_IOL
			&& (IOL_CAP_A[p] || chan_mode[6*p+:3] != CM_IOL))
			else $error("link mode on unsupported channel");
		chk_mode_flags: assert property (iol_start[p] == (chan_mode[6*p+:3] == CM_IOL)
			&& aux_power_en[p] == (chan_mode[6*p+3+:3] == CM_AUX))
			else $error("mode flags disagree");
	end
endmodule

bind icmdc_top icmdc_chk u_icmdc_chk (.clk, .reset, .cfg_commit, .do_src_iol, .ext_status_cfg,
	.event_cfg, .do_ctrl_word, .iol_out_byte0, .mst_diag_evt, .dev_err_evt, .dev_warn_evt,
	.dev_note_evt, .cfg_accepted, .cfg_rejected, .do_drive, .di_state_word, .chan_mode,
	.iol_start, .aux_power_en, .mst_diag_rep, .dev_err_rep, .dev_warn_rep, .dev_note_rep,
	.ext_status_detail, .event_detail);

// File: icmdc_netctl.sv
// Network controller model that writes, commits and reads the configuration assembly
`timescale 1ns/10ps
module icmdc_netctl (
	// Clock
	input wire logic clk,
	// Configuration access
	output logic cfg_wr,
	output logic [7:0] cfg_wr_addr,
	output logic [7:0] cfg_wr_data,
	output logic cfg_commit,
	output logic cfg_rd,
	output logic [7:0] cfg_rd_addr,
	input wire logic [7:0] cfg_rd_data,
	input wire logic cfg_accepted,
	input wire logic cfg_rejected
);
	initial begin
		cfg_wr = 1'b0;
		cfg_wr_addr = 8'h00;
		cfg_wr_data = 8'h00;
		cfg_commit = 1'b0;
		cfg_rd = 1'b0;
		cfg_rd_addr = 8'h00;
	end

	// Released lines flip so a stale value is never mistaken for a live one
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_wr_addr = a;
		cfg_wr_data = d;
		@(negedge clk);
		cfg_wr = 1'b0;
		cfg_wr_addr = ~a;
		cfg_wr_data = ~d;
	endtask

	task automatic commit(output logic acc, output logic rej);
		@(negedge clk);
		cfg_commit = 1'b1;
		@(negedge clk);
		cfg_commit = 1'b0;
		acc = cfg_accepted;
		rej = cfg_rejected;
	endtask

	task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_rd_addr = a;
		@(negedge clk);
		d = cfg_rd_data;
		cfg_rd = 1'b0;
		cfg_rd_addr = ~a;
	endtask
endmodule

// File: io_channel_mode_and_diag_config_bench.sv
// Self-checking bench for the channel mode and diagnosis block
`timescale 1ns/10ps
module io_channel_mode_and_diag_config_bench
	import icmdc_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cfg_wr, cfg_commit, cfg_rd, cfg_accepted, cfg_rejected;
	logic [7:0] cfg_wr_addr, cfg_wr_data, cfg_rd_addr, cfg_rd_data;
	logic do_src_iol = 1'b0;
	logic ext_status_cfg = 1'b0;
	logic event_cfg = 1'b0;
	logic [15:0] do_ctrl_word = 16'h0000;
	logic [15:0] di_pins = 16'h0000;
	logic [63:0] iol_out_byte0 = 64'h0;
	logic [7:0] mst_diag_evt = 8'h00;
	logic [7:0] dev_err_evt = 8'h00;
	logic [7:0] dev_warn_evt = 8'h00;
	logic [7:0] dev_note_evt = 8'h00;
	logic [15:0] do_drive, di_state_word;
	logic [47:0] chan_mode, exp_m;
	logic [7:0] iol_start, aux_power_en, ext_status_detail, event_detail;
	logic [7:0] mst_diag_rep, dev_err_rep, dev_warn_rep, dev_note_rep;
	wire logic [31:0] reps = {mst_diag_rep, dev_err_rep, dev_warn_rep, dev_note_rep};
	int err_total = 0;
	int checks_done = 0;
	logic [7:0] rst_ofs [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hd0, 8'hd1, 8'hd2, 8'hd3,
		8'hda, 8'hdb, 8'hf0, 8'h55};
	logic [7:0] dg_ofs [6] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hda, 8'hdb};

	icmdc_top u_icmdc_top (.clk, .reset, .cfg_wr, .cfg_wr_addr, .cfg_wr_data, .cfg_commit,
		.cfg_rd, .cfg_rd_addr, .cfg_rd_data, .cfg_accepted, .cfg_rejected, .do_src_iol,
		.ext_status_cfg, .event_cfg, .do_ctrl_word, .iol_out_byte0, .di_pins, .do_drive,
		.di_state_word, .chan_mode, .iol_start, .aux_power_en, .mst_diag_evt, .dev_err_evt,
		.dev_warn_evt, .dev_note_evt, .mst_diag_rep, .dev_err_rep, .dev_warn_rep,
		.dev_note_rep, .ext_status_detail, .event_detail);
	icmdc_netctl u_icmdc_netctl (.clk, .cfg_wr, .cfg_wr_addr, .cfg_wr_data, .cfg_commit,
		.cfg_rd, .cfg_rd_addr, .cfg_rd_data, .cfg_accepted, .cfg_rejected);

	always #20 clk = ~clk;

	// ********
	// Helpers
	// ********
	task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_icmdc_netctl.rd_byte(a, d);
		chk(d, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_icmdc_netctl.wr_byte(a, d);
	endtask
	task automatic commit(input logic ok);
		logic acc, rej;
		u_icmdc_netctl.commit(acc, rej);
		chk({acc, rej}, {ok, ~ok});
		repeat (2) @(negedge clk);
	endtask
	task automatic wr_modes(input logic [15:0] a, input logic [15:0] b);
		wr(OFS_MODE_A_LO, a[7:0]);
		wr(OFS_MODE_A_HI, a[15:8]);
		wr(OFS_MODE_B_LO, b[7:0]);
		wr(OFS_MODE_B_HI, b[15:8]);
	endtask
	function automatic logic [47:0] exp_mode(input logic [15:0] a, input logic [15:0] b);
		logic [2:0] fa, fb;
		exp_mode = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			case (a[2*p+:2])
				2'h0: fa = IOL_CAP_A[p] ? CM_IOL : CM_DIN;
				2'h1: fa = CM_DOUT;
				2'h2: fa = CM_DIN;
				default: fa = CM_INACTIVE;
			endcase
			case (b[2*p+:2])
				2'h0: fb = CM_DIN;
				2'h1: fb = CM_DOUT;
				2'h2: fb = CM_AUX;
				default: fb = CM_INACTIVE;
			endcase
			exp_mode[6*p+:6] = {(fa == CM_INACTIVE) ? CM_INACTIVE : fb, fa};
		end
	endfunction
	function automatic logic [15:0] msk(input logic [47:0] m, input logic [2:0] k);
		for (int c = 0; c < NUM_CH; c++) msk[c] = m[3*c+:3] == k;
	endfunction
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ********
	// Tests
	// ********
	initial begin
		repeat (3) @(negedge clk);
		reset = 1'b0;
		foreach (rst_ofs[i]) rd(rst_ofs[i], (i < 4) ? 8'hff : 8'h00);
		chk(chan_mode, 48'h0);
		$display("Test 1 done");
		wr_modes(16'hc939, 16'h1c54);
		foreach (dg_ofs[i]) wr(dg_ofs[i], 8'h01);
		commit(1'b1);
		exp_m = exp_mode(16'hc939, 16'h1c54);
		chk(chan_mode, exp_m);
		chk({iol_start, aux_power_en}, 16'h4000);
		rd(OFS_MODE_A_HI, 8'hc9);
		rd(OFS_STATUS, 8'h01);
		$display("Test 2 done");
		foreach (dg_ofs[i]) begin
			wr(dg_ofs[i], 8'h02);
			commit(1'b0);
			wr(dg_ofs[i], 8'h01);
		end
		wr(OFS_MODE_B_LO, 8'h56);
		commit(1'b0);
		rd(OFS_STATUS, 8'h03);
		chk(chan_mode, exp_m);
		wr(OFS_MODE_B_LO, 8'h54);
		$display("Test 3 done");
		do_ctrl_word = 16'hffff;
		repeat (2) @(negedge clk);
		chk(do_drive, msk(exp_m, CM_DOUT));
		do_src_iol = 1'b1;
		iol_out_byte0 = 64'hfe01fe01fe01fe01;
		repeat (2) @(negedge clk);
		chk(do_drive, 16'h9999 & msk(exp_m, CM_DOUT));
		di_pins = 16'ha5c3;
		repeat (4) @(negedge clk);
		chk(di_state_word, 16'ha5c3 & msk(exp_m, CM_DIN));
		$display("Test 4 done");
		{mst_diag_evt, dev_err_evt, dev_warn_evt, dev_note_evt} = 32'hffffffff;
		ext_status_cfg = 1'b1;
		repeat (2) @(negedge clk);
		chk(reps, 32'h40404040);
		chk({ext_status_detail, event_detail}, 16'h4000);
		wr(OFS_PORT_DIAG_LO, 8'h00);
		commit(1'b1);
		chk(reps, 32'h0);
		wr(OFS_PORT_DIAG_LO, 8'h01);
		wr(OFS_MST_DIAG, 8'h00);
		wr(OFS_DEV_WARN, 8'h00);
		event_cfg = 1'b1;
		commit(1'b1);
		chk(reps, 32'h00400040);
		chk({ext_status_detail, event_detail}, 16'h4040);
		$display("Test 5 done");
		wr_modes(16'hffff, 16'h0000);
		commit(1'b1);
		chk({chan_mode, do_drive, di_state_word}, 80'h0);
		chk(reps, 32'h0);
		$display("Test 6 done");
		stop_test();
	end

	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		stop_test();
	end
endmodule
